/* File: test/sims_mode_ctrl_sva.sv */
`timescale 1ns/1ps
module sims_chk (
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire logic                 clk_en,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [11:0]          paddr,
    input wire logic [31:0]          pwdata,
    input wire logic                 lowpwr_req,
    input wire sims_pkg::sims_hreq_s hreq,
    input wire logic                 hreq_ready,
    input wire sims_pkg::sims_mcmd_s mem_cmd,
    input wire logic [3:0]           cke,
    input wire logic                 self_refresh
);
default clocking @(posedge pclk); endclocking
default disable iff (!presetn);
////////////////////////////////////////////////////////////////////////
// shadow of select and burst, so the checker needs no hierarchy peeking
logic [2:0]  sel_q;
logic        bl_q;
logic [2:0]  exc;
wire         wr0 = psel && penable && pwrite && paddr == 12'h000 && clk_en;
wire         acc = hreq.valid && hreq_ready && cke[0];
wire  [10:0] mra = {hreq.addr[13], hreq.addr[12:3]};
always_comb begin
    case (sel_q)
        3'h1, 3'h2, 3'h3: exc = sel_q;
        3'h6:             exc = 3'h4;
        3'h7:             exc = hreq.write ? 3'h6 : 3'h5;
        default:          exc = 3'h0;
    endcase
end
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        sel_q <= 3'h0;
        bl_q  <= 1'b0;
    end else if (wr0) begin
        sel_q <= pwdata[6:4];
        bl_q  <= pwdata[2];
    end
end
////////////////////////////////////////////////////////////////////////
AST_CMD: assert property (acc |=> mem_cmd.cmd == $past(exc))
    else $error("wrong command for select");
AST_MRS: assert property (acc && sel_q == 3'h3 |=>
    {mem_cmd.mem_addr_line[11], mem_cmd.mem_addr_line[9:0]} == $past(mra))
    else $error("mode register address remap wrong");
AST_WDATA: assert property (acc && sel_q != 3'h7 |=> !mem_cmd.wr_data_en)
    else $error("write data enabled in special mode");
AST_BEATS: assert property (acc && sel_q == 3'h7 |=>
    mem_cmd.beats == ($past(bl_q) ? 4'h8 : 4'h4))
    else $error("burst beats wrong");
AST_NOCMD: assert property (cke == 4'h0 && !self_refresh |=>
    mem_cmd.cmd == 3'h0)
    else $error("command issued with cke low");
AST_SR_CKE: assert property (self_refresh |-> cke == 4'h0)
    else $error("cke high in self-refresh");
AST_LP: assert property ($rose(lowpwr_req) && cke[0] |->
    ##[1:8] self_refresh)
    else $error("no self-refresh after low-power entry");
AST_CKE_INIT: assert property (wr0 && pwdata[6:4] != 3'h0 &&
    !self_refresh && !lowpwr_req |=> cke == 4'hf)
    else $error("cke not raised by mode write");
cover property (acc && sel_q == 3'h3);
cover property (self_refresh && !lowpwr_req);
cover property ($fell(self_refresh));
endmodule
bind sims_mode_ctrl sims_chk sims_chk_i (.*);

/* File: test/sims_mode_ctrl_test.sv */
`timescale 1ns/1ps
module sims_mode_ctrl_test;
logic                 pclk = 0, presetn = 0, clk_en = 1, e;
logic                 psel = 0, penable = 0, pwrite = 0, pready, pslverr;
logic [11:0]          paddr = 12'h000;
logic [31:0]          pwdata = 32'h0, prdata, r;
logic                 suspend_req = 0, lowpwr_req = 0;
logic                 hreq_ready, self_refresh;
logic [3:0]           cke;
sims_pkg::sims_hreq_s hreq = '0;
sims_pkg::sims_mcmd_s mem_cmd, c;
int                   n_mismatch = 0, comparisons = 0, n_sre, n_wr, k;
always #5 pclk = ~pclk;
sims_mode_ctrl sims_mode_ctrl_i (.*);
sims_sdram_model sims_sdram_model_i (.*);
////////////////////////////////////////////////////////////////////////
task chk(input logic [31:0] g, input logic [31:0] x);
    comparisons++;
    if (g !== x) begin
        n_mismatch++;
        $display("ERROR %0t got %h exp %h", $time, g, x);
    end
endtask
task complete_run;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
endtask
task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
endtask
// one host cycle; the command is looked at in the cycle it stands
task host(input logic w, input logic [31:0] a);
    @(posedge pclk);
    hreq <= '{1'b1, w, a};
    @(posedge pclk);
    hreq.valid <= 1'b0;
    @(negedge pclk);
    c = mem_cmd;
endtask
task wait_sr(input logic v);
    for (k = 0; k < 20 && self_refresh !== v; k++) @(negedge pclk);
    // model tallies the entry command one edge after it stands
    @(negedge pclk);
endtask
////////////////////////////////////////////////////////////////////////
// reserved select codes are never written
// burst bit is set both ways; the model does not check it
initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h000, 0);
    chk(r, 32'h1);
    host(0, 32'h40);
    chk(c.cmd, 0);
    chk(cke, 0);
    apb(1, 12'h000, 32'h10);
    host(1, 32'h40);
    chk(cke, 4'hf);
    chk(c.cmd, 1);
    chk(c.wr_data_en, 0);
    apb(1, 12'h000, 32'h20);
    host(1, 32'h40);
    chk(c.cmd, 2);
    apb(1, 12'h000, 32'h30);
    host(0, 32'h2a58);
    chk(c.cmd, 3);
    chk({c.mem_addr_line[11], c.mem_addr_line[9:0]}, 11'h54b);
    apb(1, 12'h000, 32'h60);
    host(0, 32'h40);
    chk(c.cmd, 4);
    apb(1, 12'h000, 32'h77);
    apb(0, 12'h000, 0);
    chk(r, 32'h75);
    host(0, 32'h100);
    chk(c.cmd, 5);
    chk(c.beats, 8);
    apb(1, 12'h000, 32'h70);
    host(1, 32'h100);
    chk(c.cmd, 6);
    chk(c.beats, 4);
    @(negedge pclk);
    chk(n_wr, 1);
    apb(0, 12'h008, 0);
    chk(e, 1);
    @(posedge pclk) lowpwr_req <= 1;
    wait_sr(1);
    chk(cke, 0);
    chk(n_sre, 1);
    @(posedge pclk) lowpwr_req <= 0;
    wait_sr(0);
    host(0, 32'h100);
    chk(c.cmd, 5);
    chk(cke, 4'hf);
    @(posedge pclk) suspend_req <= 1;
    wait_sr(1);
    chk(n_sre, 2);
    @(posedge pclk) suspend_req <= 0;
    repeat (10) @(negedge pclk);
    chk(self_refresh, 1);
    @(posedge pclk) presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    // a write with the clock enable low must be lost
    clk_en <= 0;
    apb(1, 12'h000, 32'h10);
    clk_en <= 1;
    apb(0, 12'h000, 0);
    chk(r, 32'h1);
    host(0, 32'h40);
    chk(c.cmd, 0);
    chk(cke, 0);
    complete_run;
end
initial begin
    repeat (3000) @(posedge pclk);
    n_mismatch++;
    complete_run;
end
endmodule

/* File: test/sims_sdram_model.sv */
`timescale 1ns/1ps
module sims_sdram_model (
    input wire logic                 pclk,
    input wire logic                 presetn,
    input wire sims_pkg::sims_mcmd_s mem_cmd,
    input wire logic [3:0]           cke,
    output int                       n_sre,
    output int                       n_wr
);
// counts only; the ranks hold no data, a write is just tallied
always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        n_sre <= 0;
        n_wr  <= 0;
    end else begin
        if (mem_cmd.cmd == sims_pkg::SIMS_CMD_SRE)
            n_sre <= n_sre + 1;
        if (mem_cmd.wr_data_en && cke[0])
            n_wr <= n_wr + 1;
    end
end
endmodule

/* File: verilog/sims_cmd_decode.sv */
`timescale 1ns/1ps
module sims_cmd_decode (
    input  wire logic [2:0]          special_op_select,
    input  wire logic                burst_len_sel,
    input  wire sims_pkg::sims_hreq_s hreq,
    output sims_pkg::sims_mcmd_s     mcmd
);

    logic [31:0] host_addr_line;

    assign host_addr_line = hreq.addr;

    always_comb begin
        mcmd               = '0;
        mcmd.cmd           = sims_pkg::SIMS_CMD_NONE;
        mcmd.mem_addr_line = '0;
        mcmd.beats         = '0;
        mcmd.wr_data_en    = 1'b0;
        if (hreq.valid) begin
            unique case (special_op_select)
                sims_pkg::SEL_NOP: begin
                    mcmd.cmd = sims_pkg::SIMS_CMD_NOP;             // [RL7]
                end
                sims_pkg::SEL_PRECHARGE: begin
                    mcmd.cmd = sims_pkg::SIMS_CMD_PREA;            // [RL8]
                end
                sims_pkg::SEL_MRS: begin
                    mcmd.cmd = sims_pkg::SIMS_CMD_MRS;             // [RL9]
                    mcmd.mem_addr_line[9:0] = host_addr_line[12:3]; // [RL10]
                    mcmd.mem_addr_line[11]  = host_addr_line[13];  // [RL10]
                end
                sims_pkg::SEL_REFRESH: begin
                    mcmd.cmd = sims_pkg::SIMS_CMD_REF;             // [RL11]
                end
                sims_pkg::SEL_NORMAL: begin
                    mcmd.cmd = hreq.write ? sims_pkg::SIMS_CMD_WRITE
                                          : sims_pkg::SIMS_CMD_READ; // [RL12]
                    mcmd.mem_addr_line = host_addr_line[16:3];
                    mcmd.wr_data_en    = hreq.write;
                    mcmd.beats = burst_len_sel ? sims_pkg::BEATS_BL8
                                               : sims_pkg::BEATS_BL4; // [RL14]
                end
                // post-reset and reserved codes issue nothing
                default: begin
                    mcmd.cmd = sims_pkg::SIMS_CMD_NONE;
                end
            endcase
        end
    end

endmodule

/* File: verilog/sims_mode_ctrl.sv */
// Overview of operation
// RL1: reset clears mode field, holds cke low
// RL2: cke rises on first non-reset mode write
// RL3: suspend flushes commands, enters self-refresh
// RL4: resume reset restores post-reset code, cke low
// RL5: c3/s1 entry flushes, enters self-refresh
// RL6: c3/s1 exit leaves self-refresh unaided
// RL7: nop code makes host cycles nop
// RL8: precharge code makes precharge-all commands
// RL9: mode-register code makes mode register sets
// RL10: host addr 12:3 to 9:0, 13 to 11
// RL11: refresh code makes cbr refresh cycles
// RL12: normal code makes reads and writes
// RL13: software avoids reserved mode code
// RL14: burst bit selects four or eight
// RL15: software matches burst bit to modules
// RL16: read-only type field reads ddr
// RL17: one command per cycle, write data only for normal-code writes
`timescale 1ns/1ps
module sims_mode_ctrl (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 clk_en,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire logic                 suspend_req,
    input  wire logic                 lowpwr_req,
    input  wire sims_pkg::sims_hreq_s hreq,
    output logic                      hreq_ready,
    output sims_pkg::sims_mcmd_s      mem_cmd,
    output logic [3:0]                cke,
    output logic                      self_refresh
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef enum logic [3:0] {
        SIMS_ST_RUN   = 4'h1,
        SIMS_ST_FLUSH = 4'h2,
        SIMS_ST_SR    = 4'h4,
        SIMS_ST_EXIT  = 4'h8
    } sims_pwr_e;

    sims_pwr_e            pwr_q, pwr_d;
    logic [2:0]           sel_q;
    logic                 bl_q;
    logic                 cke_on_q;
    logic                 pend_q;
    logic                 susp_q;
    sims_pkg::sims_mcmd_s cmd_d;
    sims_pkg::sims_mcmd_s mem_cmd_q;
    logic                 wr_en, rd_en;
    logic                 take_req;
    logic                 lp_enter;

    assign wr_en    = psel && penable && pwrite;
    assign rd_en    = psel && !pwrite;
    assign pready   = 1'b1;
    assign lp_enter = suspend_req || lowpwr_req;
    // only normal run accepts host cycles; flushing blocks new ones
    assign hreq_ready = (pwr_q == SIMS_ST_RUN) && !lp_enter;
    assign take_req   = hreq.valid && hreq_ready && cke_on_q;

    ////////////////////////////////////////////////////////////////////////
    // apb errors on unmapped offsets

    always_comb begin
        pslverr = psel && penable
                  && (paddr != sims_pkg::ADDR_MODE_CTRL)
                  && (paddr != sims_pkg::ADDR_PWR_STATUS);
    end

    ////////////////////////////////////////////////////////////////////////
    // mode control register

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q <= sims_pkg::SEL_POST_RESET;                     // [RL1] [RL4]
            bl_q  <= 1'b0;                                          // [RL14]
        end else if (clk_en && wr_en
                     && paddr == sims_pkg::ADDR_MODE_CTRL) begin
            sel_q <= pwdata[sims_pkg::SEL_LSB +: 3];
            bl_q  <= pwdata[sims_pkg::BL_BIT];
        end
    end

    // cke latches on once software leaves the post-reset code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cke_on_q <= 1'b0;                                       // [RL1] [RL4]
        end else if (clk_en && wr_en
                     && paddr == sims_pkg::ADDR_MODE_CTRL
                     && pwdata[sims_pkg::SEL_LSB +: 3]
                        != sims_pkg::SEL_POST_RESET) begin
            cke_on_q <= 1'b1;                                       // [RL2]
        end
    end

    always_comb begin
        prdata = '0;
        if (rd_en && paddr == sims_pkg::ADDR_MODE_CTRL) begin
            prdata[sims_pkg::SEL_LSB +: 3]  = sel_q;
            prdata[sims_pkg::BL_BIT]        = bl_q;
            prdata[sims_pkg::TYPE_LSB +: 2] = sims_pkg::TYPE_RESET; // [RL16]
        end else if (rd_en && paddr == sims_pkg::ADDR_PWR_STATUS) begin
            prdata[sims_pkg::STAT_SR_BIT]  = (pwr_q == SIMS_ST_SR);
            prdata[sims_pkg::STAT_CKE_BIT] = |cke;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // low-power sequencer

    // a suspend exit only happens through reset, so remember it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            susp_q <= 1'b0;
        end else if (clk_en && suspend_req) begin
            susp_q <= 1'b1;                                         // [RL3]
        end
    end

    always_comb begin
        pwr_d = pwr_q;
        unique case (pwr_q)
            SIMS_ST_RUN: begin
                if (lp_enter) begin
                    pwr_d = SIMS_ST_FLUSH;                          // [RL3] [RL5]
                end
            end
            SIMS_ST_FLUSH: begin
                if (!pend_q) begin
                    pwr_d = SIMS_ST_SR;                             // [RL3] [RL5]
                end
            end
            SIMS_ST_SR: begin
                if (!lp_enter && !susp_q) begin
                    pwr_d = SIMS_ST_EXIT;                           // [RL6]
                end
            end
            SIMS_ST_EXIT: begin
                pwr_d = SIMS_ST_RUN;                                // [RL6]
            end
            default: begin
                pwr_d = SIMS_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_q <= SIMS_ST_RUN;
        end else if (clk_en) begin
            pwr_q <= pwr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command issue: one memory command per accepted host cycle

    sims_cmd_decode u_decode (
        .special_op_select (sel_q),
        .burst_len_sel     (bl_q),
        .hreq              (hreq),
        .mcmd              (cmd_d)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_cmd_q <= '0;
            pend_q    <= 1'b0;
        end else if (clk_en) begin
            pend_q <= take_req;                                     // [RL3]
            if (take_req) begin
                mem_cmd_q <= cmd_d;                                 // [RL17]
            end else if (pwr_q == SIMS_ST_FLUSH && !pend_q) begin
                mem_cmd_q     <= '0;
                mem_cmd_q.cmd <= sims_pkg::SIMS_CMD_SRE;            // [RL5]
            end else begin
                mem_cmd_q <= '0;
            end
        end
    end

    assign mem_cmd = mem_cmd_q;

    ////////////////////////////////////////////////////////////////////////
    // clock enables: low in reset, before init, and in self-refresh

    genvar r;
    generate
        for (r = 0; r < sims_pkg::NUM_RANKS; r = r + 1) begin : g_cke
            assign cke[r] = cke_on_q && (pwr_q != SIMS_ST_SR); // [RL2] [RL6]
        end
    endgenerate

    assign self_refresh = (pwr_q == SIMS_ST_SR);

endmodule

/* File: verilog/sims_pkg.sv */
package sims_pkg;

    // register map (offset chosen locally)
    localparam logic [11:0] ADDR_MODE_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_PWR_STATUS  = 12'h004;

    // field positions in the mode control word
    localparam int          SEL_LSB          = 4;
    localparam int          BL_BIT           = 2;
    localparam int          TYPE_LSB         = 0;

    // power status word: bit 0 ranks in self-refresh, bit 1 cke level
    localparam int          STAT_SR_BIT      = 0;
    localparam int          STAT_CKE_BIT     = 1;

    localparam logic [2:0]  SEL_POST_RESET   = 3'h0;
    localparam logic [2:0]  SEL_NOP          = 3'h1;
    localparam logic [2:0]  SEL_PRECHARGE    = 3'h2;
    localparam logic [2:0]  SEL_MRS          = 3'h3;
    localparam logic [2:0]  SEL_REFRESH      = 3'h6;
    localparam logic [2:0]  SEL_NORMAL       = 3'h7;

    localparam logic [1:0]  TYPE_DDR         = 2'h1;
    localparam logic [1:0]  TYPE_DDR2        = 2'h2;
    localparam logic [1:0]  TYPE_RESET       = TYPE_DDR;

    localparam int          NUM_RANKS        = 4;
    localparam logic [3:0]  BEATS_BL4        = 4'h4;
    localparam logic [3:0]  BEATS_BL8        = 4'h8;

    // memory command codes
    typedef enum logic [2:0] {
        SIMS_CMD_NONE  = 3'h0,
        SIMS_CMD_NOP   = 3'h1,
        SIMS_CMD_PREA  = 3'h2,
        SIMS_CMD_MRS   = 3'h3,
        SIMS_CMD_REF   = 3'h4,
        SIMS_CMD_READ  = 3'h5,
        SIMS_CMD_WRITE = 3'h6,
        SIMS_CMD_SRE   = 3'h7
    } sims_cmd_e;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic [31:0] addr;
    } sims_hreq_s;

    typedef struct packed {
        sims_cmd_e   cmd;
        logic [13:0] mem_addr_line;
        logic [3:0]  beats;
        logic        wr_data_en;
    } sims_mcmd_s;

endpackage
